/* File: design/hpsc_consts.vh */
`ifndef HPSC_CONSTS_VH
`define HPSC_CONSTS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define HPSC_ADDR_CTRL_A 8'h02
`define HPSC_ADDR_CTRL_B 8'h03
`define HPSC_ADDR_STAT_A 8'h04
`define HPSC_ADDR_STAT_B 8'h05
`define HPSC_ADDR_SHARED 8'h06
// ----------------------------------------
// Reset values
// ----------------------------------------
`define HPSC_CTRL_RESET 3'h0
`define HPSC_MASK_RESET 1'h0
// ----------------------------------------
// Field positions
// ----------------------------------------
`define HPSC_CTRL_AUX_EN 0
`define HPSC_CTRL_MAIN_EN 1
`define HPSC_CTRL_INHIBIT 2
`define HPSC_STAT_F3V 0
`define HPSC_STAT_F12V 2
`define HPSC_STAT_FAUX 4
`define HPSC_SH_OT 1
`define HPSC_SH_UV 2
`define HPSC_SH_MASK 3
// ----------------------------------------
// Timing
// ----------------------------------------
`define HPSC_CLK_MHZ 50
`define HPSC_DEGLITCH_MS 5
`define HPSC_DEGLITCH_CYC (`HPSC_DEGLITCH_MS * 1000 * `HPSC_CLK_MHZ)
`endif

/* File: design/hpsc_regs.v */
// Behaviour
// RL1: control accepts 00h-07h: aux, main, inhibit
// RL2: control write in direct mode forces SMBus
// RL3: control read: main good bit6, aux bit7
// RL4: aux good needs enable and output good
// RL5: main good needs enable, both outputs good
// RL6: inhibit bit makes force pin ignored
// RL7: main on needs enable, no fault, aux ok
// RL8: host clears fault by enable off then on
// RL9: aux on needs enable, no fault, input ok
// RL10: status bits 7,6,5 state; 4,2,0 flags
// RL11: fault bit mirrors pin, inactive under SMBus; the code shows the fault latch, which stays set while force releases the pin
// RL12: force pin low releases fault pin
// RL13: internal-on bits show actual supply state
// RL14: aux flag on overcurrent timeout or thermal
// RL15: main flags on timeout, thermal or fast trip
// RL16: write one clears flag, interrupt released
// RL17: host cycles enable and clears flag
// RL18: shared: inputs, mask, undervoltage, overtemp
// RL19: inputs reported after stable deglitch time
// RL20: mask low lets faults drive interrupt
// RL21: undervoltage flag only while main enabled
// RL22: echoed flag clears on next read if gone
// RL23: reserved bits read zero
// RL24: overtemp flag at stage two limit
// RL25: reserved writes and zero writes ignored
// RL26: interrupt while any unmasked flag set
`timescale 1ns/1ps
`include "hpsc_consts.vh"
module hpsc_regs #(
   parameter DEGLITCH_CYCLES = `HPSC_DEGLITCH_CYC
) (
   // Clock and reset
   input wire clock,
   input wire reset,
   // Register port
   input wire [7:0] reg_addr,
   input wire reg_write,
   input wire reg_read,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   // Direct mode pins, index 0 slot A, 1 slot B
   input wire [1:0] aux_en_pin,
   input wire [1:0] main_en_pin,
   input wire [1:0] force_on_pin_n,
   // Analog monitors
   input wire [1:0] aux_output_good,
   input wire [1:0] three_volt_good,
   input wire [1:0] twelve_volt_good,
   input wire [1:0] aux_input_ok,
   input wire [1:0] aux_oc_timeout,
   input wire [1:0] three_oc_timeout,
   input wire [1:0] twelve_oc_timeout,
   input wire [1:0] aux_oc_active,
   input wire [1:0] three_oc_active,
   input wire [1:0] twelve_oc_active,
   input wire [1:0] three_fast_trip,
   input wire [1:0] twelve_fast_trip,
   input wire [1:0] main_supply_low,
   input wire [1:0] aux_supply_low,
   input wire thermal_limit_stage_one,
   input wire thermal_limit_stage_two,
   // General inputs: a1, b1, a2, b2
   input wire [3:0] general_input,
   // Supply switches
   output reg [1:0] main_internal_on,
   output reg [1:0] aux_internal_on,
   // Open-drain pins, enable low while driving
   output wire [1:0] slot_fault_out,
   output wire [1:0] slot_fault_oe_n,
   output wire irq_out,
   output wire irq_oe_n,
   output reg smbus_mode
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   reg [2:0] ctrl [0:1];
   reg [1:0] aux_fault_latch, main_fault_latch;
   reg [1:0] f_aux, f_12, f_3;
   reg [1:0] e_aux, e_12, e_3;
   reg uv_flag, ot_flag, e_uv, e_ot, irq_pin_mask;
   reg [3:0] gpi_stable, gpi_last;
   reg [31:0] gpi_cnt [0:3];
   reg [1:0] aux_on_req, main_on_req;
   reg [1:0] force_act;
   reg [1:0] aux_oc_evt, three_evt, twelve_evt;
   reg [1:0] fault_pin_low, fault_latched;
   reg uv_cond;
   // Loop indices, one per process
   integer i;
   integer j;
   integer n;

   function wr_hit;
      input [7:0] a;
      input [7:0] t;
      input w;
      begin
         wr_hit = w && (a == t);
      end
   endfunction

   // Over-current event: held fault with timeout or first thermal
   // limit, or a fast trip where the supply has one
   function oc_event;
      input active;
      input timeout;
      input stage_one;
      input fast;
      begin
         oc_event = (active & (timeout | stage_one)) | fast;
      end
   endfunction

   // ----------------------------------------
   // Combinational control
   // ----------------------------------------
   always @* begin
      uv_cond = 1'b0;
      for (j = 0; j < 2; j = j + 1) begin
         // Force pin honoured only when not inhibited
         force_act[j] = ~force_on_pin_n[j] &
            ~ctrl[j][`HPSC_CTRL_INHIBIT]; // RL6
         aux_on_req[j] = smbus_mode ? ctrl[j][`HPSC_CTRL_AUX_EN] :
            aux_en_pin[j];
         main_on_req[j] = smbus_mode ? ctrl[j][`HPSC_CTRL_MAIN_EN] :
            main_en_pin[j];
         aux_oc_evt[j] = oc_event(aux_oc_active[j], aux_oc_timeout[j],
            thermal_limit_stage_one, 1'b0); // RL14
         three_evt[j] = oc_event(three_oc_active[j], three_oc_timeout[j],
            thermal_limit_stage_one, three_fast_trip[j]); // RL15
         twelve_evt[j] = oc_event(twelve_oc_active[j],
            twelve_oc_timeout[j], thermal_limit_stage_one,
            twelve_fast_trip[j]); // RL15
         fault_latched[j] = aux_fault_latch[j] | main_fault_latch[j];
         // Pin shows the latch; the status bit keeps it under force
         fault_pin_low[j] = fault_latched[j] & ~force_act[j]; // RL12
         if (main_on_req[j] & main_supply_low[j])
            uv_cond = 1'b1; // RL21
      end
   end

   // Fault pin released while forced; inactive meaning under SMBus only in bit
   assign slot_fault_out = 2'h0;
   assign slot_fault_oe_n = ~fault_pin_low; // RL12
   // Interrupt on any unmasked flag
   assign irq_out = 1'b0;
   assign irq_oe_n = ~(~irq_pin_mask & (|f_aux | |f_12 | |f_3 |
      uv_flag | ot_flag)); // RL20 RL26

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always @(posedge clock) begin
      if (reset) begin
         smbus_mode <= 1'b0;
         ctrl[0] <= `HPSC_CTRL_RESET;
         ctrl[1] <= `HPSC_CTRL_RESET;
         aux_fault_latch <= 2'h0;
         main_fault_latch <= 2'h0;
         main_internal_on <= 2'h0;
         aux_internal_on <= 2'h0;
         f_aux <= 2'h0;
         f_12 <= 2'h0;
         f_3 <= 2'h0;
         e_aux <= 2'h0;
         e_12 <= 2'h0;
         e_3 <= 2'h0;
         uv_flag <= 1'b0;
         ot_flag <= 1'b0;
         e_uv <= 1'b0;
         e_ot <= 1'b0;
         irq_pin_mask <= `HPSC_MASK_RESET;
      end else begin
         for (i = 0; i < 2; i = i + 1) begin
            if (wr_hit(reg_addr, `HPSC_ADDR_CTRL_A + i[7:0], reg_write)) begin
               ctrl[i] <= reg_wdata[2:0]; // RL1 RL25
               // Mode latch: only reset leaves SMBus control
               smbus_mode <= 1'b1; // RL2
            end
            // Latch clears only while enable is low
            if (!aux_on_req[i])
               aux_fault_latch[i] <= 1'b0; // RL8
            else if (aux_oc_evt[i] | thermal_limit_stage_two)
               aux_fault_latch[i] <= 1'b1;
            if (!main_on_req[i])
               main_fault_latch[i] <= 1'b0; // RL8
            else if (three_evt[i] | twelve_evt[i] | main_supply_low[i] |
               thermal_limit_stage_two)
               main_fault_latch[i] <= 1'b1;
            // Force skips faults but not aux input lockout or stage two
            main_internal_on[i] <= aux_input_ok[i] & ~thermal_limit_stage_two
               & ((main_on_req[i] & ~main_fault_latch[i]) | force_act[i]); // RL7 RL13
            aux_internal_on[i] <= aux_input_ok[i] & ~aux_supply_low[i] &
               ~thermal_limit_stage_two &
               ((aux_on_req[i] & ~aux_fault_latch[i]) | force_act[i]); // RL9 RL13
            // Echo reset: write one arms, next read clears if gone
            if (wr_hit(reg_addr, `HPSC_ADDR_STAT_A + i[7:0], reg_write)) begin
               // Arm only a set flag: a stale arm would eat a later fault
               e_aux[i] <= e_aux[i] |
                  (reg_wdata[`HPSC_STAT_FAUX] & f_aux[i]); // RL16 RL25
               e_12[i] <= e_12[i] |
                  (reg_wdata[`HPSC_STAT_F12V] & f_12[i]);
               e_3[i] <= e_3[i] | (reg_wdata[`HPSC_STAT_F3V] & f_3[i]);
            end
            if (wr_hit(reg_addr, `HPSC_ADDR_STAT_A + i[7:0], reg_read)) begin
               if (e_aux[i] & ~aux_oc_evt[i]) begin
                  f_aux[i] <= 1'b0; // RL22
                  e_aux[i] <= 1'b0;
               end
               if (e_12[i] & ~twelve_evt[i]) begin
                  f_12[i] <= 1'b0; // RL22
                  e_12[i] <= 1'b0;
               end
               if (e_3[i] & ~three_evt[i]) begin
                  f_3[i] <= 1'b0; // RL22
                  e_3[i] <= 1'b0;
               end
            end
            // Set wins over clear
            if (aux_oc_evt[i])
               f_aux[i] <= 1'b1; // RL14
            if (twelve_evt[i])
               f_12[i] <= 1'b1; // RL15
            if (three_evt[i])
               f_3[i] <= 1'b1; // RL15
         end
         if (wr_hit(reg_addr, `HPSC_ADDR_SHARED, reg_write)) begin
            irq_pin_mask <= reg_wdata[`HPSC_SH_MASK]; // RL18
            e_uv <= e_uv | (reg_wdata[`HPSC_SH_UV] & uv_flag); // RL21
            e_ot <= e_ot | (reg_wdata[`HPSC_SH_OT] & ot_flag); // RL24
         end
         if (wr_hit(reg_addr, `HPSC_ADDR_SHARED, reg_read)) begin
            if (e_uv & ~uv_cond) begin
               uv_flag <= 1'b0; // RL22
               e_uv <= 1'b0;
            end
            if (e_ot & ~thermal_limit_stage_two) begin
               ot_flag <= 1'b0; // RL22
               e_ot <= 1'b0;
            end
         end
         // Flag reads zero whenever no main supply is requested
         if (!(|main_on_req))
            uv_flag <= 1'b0; // RL21
         else if (uv_cond)
            uv_flag <= 1'b1; // RL21
         if (thermal_limit_stage_two)
            ot_flag <= 1'b1; // RL24
      end
   end

   // ----------------------------------------
   // General input deglitch
   // ----------------------------------------
   // Counter stops at the limit, so a long steady input never wraps
   always @(posedge clock) begin
      for (n = 0; n < 4; n = n + 1) begin
         if (reset) begin
            gpi_cnt[n] <= 32'h0;
            gpi_last[n] <= 1'b0;
            gpi_stable[n] <= 1'b0;
         end else if (general_input[n] != gpi_last[n]) begin
            gpi_last[n] <= general_input[n];
            gpi_cnt[n] <= 32'h0;
         end else if (gpi_cnt[n] >= DEGLITCH_CYCLES - 1) begin
            gpi_stable[n] <= gpi_last[n]; // RL19
         end else begin
            gpi_cnt[n] <= gpi_cnt[n] + 32'h1;
         end
      end
   end

   // ----------------------------------------
   // Read data, registered for next cycle
   // ----------------------------------------
   always @(posedge clock) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         case (reg_addr)
            `HPSC_ADDR_CTRL_A, `HPSC_ADDR_CTRL_B: begin
               reg_rdata <= {aux_on_req[reg_addr[0]] &
                  aux_output_good[reg_addr[0]],
                  main_on_req[reg_addr[0]] & three_volt_good[reg_addr[0]] &
                  twelve_volt_good[reg_addr[0]],
                  3'h0, ctrl[reg_addr[0]]}; // RL3 RL4 RL5 RL23
            end
            `HPSC_ADDR_STAT_A, `HPSC_ADDR_STAT_B: begin
               // Latched fault, not the pin: force only releases the pin
               reg_rdata <= {fault_latched[reg_addr[0]] & ~smbus_mode,
                  main_internal_on[reg_addr[0]],
                  aux_internal_on[reg_addr[0]],
                  f_aux[reg_addr[0]], 1'b0, f_12[reg_addr[0]], 1'b0,
                  f_3[reg_addr[0]]}; // RL10 RL11 RL13 RL23
            end
            `HPSC_ADDR_SHARED: begin
               reg_rdata <= {gpi_stable[3], gpi_stable[2], gpi_stable[1],
                  gpi_stable[0], irq_pin_mask, uv_flag, ot_flag,
                  1'b0}; // RL18 RL23
            end
            default: begin
               reg_rdata <= 8'h00; // RL23
            end
         endcase
      end
   end
endmodule

/* File: tb/hpsc_regs_monitor.sv */
`timescale 1ns/1ps
module hpsc_regs_monitor (
   // Clock and register port
   input wire clock,
   input wire reset,
   input wire [7:0] reg_addr,
   input wire reg_write,
   input wire reg_read,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   // Pins
   input wire [1:0] force_on_pin_n,
   input wire [1:0] aux_input_ok,
   input wire [1:0] aux_internal_on,
   input wire [1:0] slot_fault_out,
   input wire [1:0] slot_fault_oe_n,
   input wire irq_out,
   input wire irq_oe_n,
   input wire smbus_mode
);
   reg mask_q;
   reg inh_q;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // ----------------------------------------
   // Shadow of mask and slot A inhibit
   // ----------------------------------------
   always @(posedge clock) begin
      if (reset) begin
         mask_q <= 1'h0;
         inh_q <= 1'h0;
      end else if (reg_write) begin
         if (reg_addr == 8'h06) mask_q <= reg_wdata[3];
         if (reg_addr == 8'h02) inh_q <= reg_wdata[2];
      end
   end
   property p_set; reg_write && reg_addr[7:1] == 7'h01 |=> smbus_mode;
   endproperty
   a_set: assert property (p_set) else $error("mode not set");
   property p_keep; smbus_mode |=> smbus_mode; endproperty
   a_keep: assert property (p_keep) else $error("mode left");
   property p_unmap; reg_read && (reg_addr < 8'h02 || reg_addr > 8'h06)
      |=> reg_rdata == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped");
   property p_crsv; reg_read && reg_addr[7:1] == 7'h01
      |=> reg_rdata[5:3] == 3'h0; endproperty
   a_crsv: assert property (p_crsv) else $error("ctrl rsvd");
   property p_srsv; reg_read && reg_addr[7:1] == 7'h02
      |=> !reg_rdata[3] && !reg_rdata[1]; endproperty
   a_srsv: assert property (p_srsv) else $error("stat rsvd");
   property p_fbit; smbus_mode && reg_read && reg_addr == 8'h04
      |=> !reg_rdata[7]; endproperty
   a_fbit: assert property (p_fbit) else $error("fault bit");
   property p_aux; !aux_input_ok[0] |-> ##[1:2] !aux_internal_on[0];
   endproperty
   a_aux: assert property (p_aux) else $error("aux on");
   property p_mask; mask_q |-> irq_oe_n; endproperty
   a_mask: assert property (p_mask) else $error("irq masked");
   property p_force; !force_on_pin_n[0] && !inh_q |-> slot_fault_oe_n[0];
   endproperty
   a_force: assert property (p_force) else $error("fault pin");
   property p_od; slot_fault_out == 2'h0 && !irq_out; endproperty
   a_od: assert property (p_od) else $error("open drain");
endmodule
bind hpsc_regs hpsc_regs_monitor u_mon (.clock(clock), .reset(reset),
   .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .force_on_pin_n(force_on_pin_n), .aux_input_ok(aux_input_ok),
   .aux_internal_on(aux_internal_on), .slot_fault_out(slot_fault_out),
   .slot_fault_oe_n(slot_fault_oe_n), .irq_out(irq_out),
   .irq_oe_n(irq_oe_n), .smbus_mode(smbus_mode));

/* File: tb/hpsc_host.sv */
`timescale 1ns/1ps
module hpsc_host (
   // Clock and read data
   input wire clock,
   input wire [7:0] reg_rdata,
   // Requests
   output reg [7:0] reg_addr,
   output reg reg_write,
   output reg reg_read,
   output reg [7:0] reg_wdata
);
   initial begin
      reg_addr = 8'h00;
      reg_write = 1'h0;
      reg_read = 1'h0;
      reg_wdata = 8'h00;
   end
   // Idle bus shows inverted values so stale data is never trusted
   task wr(input [7:0] a, input [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'h1;
      @(posedge clock);
      reg_write <= 1'h0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   task rd(input [7:0] a, output [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'h1;
      @(posedge clock);
      reg_read <= 1'h0;
      reg_addr <= ~a;
      @(negedge clock);
      d = reg_rdata;
   endtask
endmodule

/* File: tb/tb_hpsc_regs.sv */
`timescale 1ns/1ps
module tb_hpsc_regs;
   reg clock;
   reg reset;
   reg s;
   reg [1:0] aen, men, frc_n, ga, g3, g12, aok;
   reg [15:0] fv;
   reg [3:0] gin;
   reg [7:0] d, e, a;
   wire [7:0] addr, wdata, rdata;
   wire wr_s, rd_s, irq_oe_n, smb;
   wire [1:0] main_on;
   integer fails, checked, k, seed;
   hpsc_host host (.clock(clock), .reg_rdata(rdata), .reg_addr(addr),
      .reg_write(wr_s), .reg_read(rd_s), .reg_wdata(wdata));
   hpsc_regs #(.DEGLITCH_CYCLES(4)) DUT (.clock(clock), .reset(reset),
      .reg_addr(addr), .reg_write(wr_s), .reg_read(rd_s),
      .reg_wdata(wdata), .reg_rdata(rdata), .aux_en_pin(aen),
      .main_en_pin(men), .force_on_pin_n(frc_n), .aux_output_good(ga),
      .three_volt_good(g3), .twelve_volt_good(g12), .aux_input_ok(aok),
      .aux_oc_timeout(fv[5:4]), .three_oc_timeout(fv[7:6]),
      .twelve_oc_timeout(fv[9:8]), .aux_oc_active(fv[5:4]),
      .three_oc_active(fv[7:6]), .twelve_oc_active(fv[9:8]),
      .three_fast_trip(fv[1:0]), .twelve_fast_trip(fv[3:2]),
      .main_supply_low(fv[11:10]), .aux_supply_low(fv[15:14]),
      .thermal_limit_stage_one(fv[13]), .thermal_limit_stage_two(fv[12]),
      .general_input(gin), .main_internal_on(main_on),
      .aux_internal_on(), .slot_fault_out(), .slot_fault_oe_n(),
      .irq_out(), .irq_oe_n(irq_oe_n), .smbus_mode(smb));
   function [7:0] exp_ctrl(input [2:0] v, input [2:0] g);
      exp_ctrl = {v[0] & g[0], v[1] & g[1] & g[2], 3'h0, v};
   endfunction
   function [7:0] flag(input integer n);
      flag = (n == 6) ? 8'h02 : (n == 5) ? 8'h04 : 8'h01 << (2 * (n % 3));
   endfunction
   task chk(input [7:0] seen, input [7:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task report_and_stop;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      clock = 1'h0;
      forever #10 clock = ~clock;
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge clock);
      fails = fails + 1;
      report_and_stop;
   end
   initial begin
      reset = 1'h1;
      {aen, men, ga, g3, g12, fv, gin} = 30'h0;
      {frc_n, aok} = 4'hF;
      fails = 0;
      checked = 0;
      seed = $urandom(31);
      repeat (5) @(posedge clock);
      reset <= 1'h0;
      for (k = 0; k < 8; k = k + 1) begin
         host.rd(k[7:0], d);
         chk(d, 8'h00);
      end
      $display("reset values done");
      // ----------------------------------------
      // Pin control before any control write
      // ----------------------------------------
      @(posedge clock);
      {aen, men, ga, g3, g12, frc_n} <= 12'h5FE;
      repeat (3) @(posedge clock);
      host.rd(8'h02, d);
      chk(d, 8'hC0);
      host.rd(8'h04, d);
      chk(d, 8'h60);
      @(posedge clock);
      fv <= 16'h0001;
      @(posedge clock);
      fv <= 16'h0000;
      host.rd(8'h04, d);
      chk(d, 8'hE1);
      host.wr(8'h04, 8'h01);
      host.rd(8'h04, d);
      host.rd(8'h04, d);
      chk(d, 8'hE0);
      @(posedge clock);
      aok <= 2'h2;
      repeat (3) @(posedge clock);
      host.rd(8'h04, d);
      chk(d, 8'h80);
      chk(smb, 1'h0);
      @(posedge clock);
      {aen, men, frc_n, aok} <= 8'h0F;
      $display("direct mode done");
      for (k = 0; k < 8; k = k + 1) begin
         e = $urandom;
         s = $urandom;
         @(posedge clock);
         {ga, g3, g12} <= {{2{e[0]}}, {2{e[1]}}, {2{e[2]}}};
         host.wr({7'h01, s}, k[7:0]);
         @(negedge clock);
         chk(smb, 1'h1);
         host.rd({7'h01, s}, d);
         chk(d, exp_ctrl(k[2:0], e[2:0]));
      end
      {ga, g3, g12} <= 6'h3F;
      $display("control done");
      for (k = 0; k < 7; k = k + 1) begin
         s = $urandom;
         e = flag(k);
         a = (k > 4) ? 8'h06 : {7'h02, s};
         host.wr({7'h01, s}, 8'h03);
         fv <= (k == 6) ? 16'h1000 : 16'h1 << (2 * k + s);
         repeat (2) @(posedge clock);
         fv <= 16'h0;
         host.rd(a, d);
         chk(d & e, e);
         chk(irq_oe_n, 1'h0);
         host.wr(8'h06, 8'h08);
         @(negedge clock);
         chk(irq_oe_n, 1'h1);
         host.wr(8'h06, 8'h00);
         host.wr(a, e);
         host.rd(a, d);
         host.rd(a, d);
         chk(d & e, 8'h00);
         chk(irq_oe_n, 1'h1);
         host.wr({7'h01, s}, 8'h00);
         host.wr({7'h01, s}, 8'h03);
         repeat (3) @(posedge clock);
         chk(main_on[s], 1'h1);
      end
      $display("fault flags done");
      // Single-cycle glitch must not reach the register
      e = $urandom;
      gin <= e[3:0];
      repeat (10) @(posedge clock);
      gin <= ~e[3:0];
      @(posedge clock);
      gin <= e[3:0];
      repeat (10) @(posedge clock);
      host.rd(8'h06, d);
      chk(d, {e[3:0], 4'h0});
      $display("inputs done");
      report_and_stop;
   end
endmodule
